/* File: common/csp_pkg.sv */
// current sense processor constants: register map, field layout, timing
// assumes a single system clock; dividers derive sample and peak strobes
package csp_pkg;
	// timing
	localparam longint CLK_HZ       = 64'd10_000_000;
	localparam longint SAMPLE_HZ    = 64'd25_000_000;
	localparam longint PEAK_HZ      = 64'd100_000_000;
	localparam longint BLANK_MAX_NS = 64'd280;
	localparam longint NS_PER_S     = 64'd1_000_000_000;
	// converter
	localparam int     EST_W        = 13;
	localparam int     DAC_LEVELS   = 640;
	localparam int     EST_FRAC     = 3;
	localparam int     EST_MAX      = (DAC_LEVELS << EST_FRAC) - 1;
	localparam int     LSB_HIGH_UV  = 100;
	localparam int     LSB_LOW_UV   = 1450;
	localparam int     CUR_W        = 26;
	localparam int     TC_SHIFT     = 16;
	localparam int     LC_SHIFT     = 4;
	localparam int     AVG_LOG2     = 3;
	// register byte addresses
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_OFFSET = 8'h04;
	localparam logic [7:0] A_BLANK  = 8'h08;
	localparam logic [7:0] A_SLOPE  = 8'h0c;
	localparam logic [7:0] A_CORR   = 8'h10;
	localparam logic [7:0] A_OC     = 8'h14;
	localparam logic [7:0] A_UC     = 8'h18;
	localparam logic [7:0] A_IOC    = 8'h1c;
	localparam logic [7:0] A_PEAK   = 8'h20;
	localparam logic [7:0] A_HIZ    = 8'h24;
	localparam logic [7:0] A_STAT   = 8'h28;
	localparam logic [7:0] A_MASK   = 8'h2c;
	localparam logic [7:0] A_EST    = 8'h30;
	localparam logic [7:0] A_AVG    = 8'h34;
	localparam logic [7:0] A_CUR    = 8'h38;
	// control bits
	localparam int C_GAIN_HIGH  = 0;
	localparam int C_STAGE_MODE = 1;
	localparam int C_PRIMARY    = 2;
	localparam int C_PEAK_MODE  = 3;
	localparam int C_LCOMP_EN   = 4;
	localparam int C_TCOMP_EN   = 5;
	localparam int CTRL_W       = 6;
	// status and mask bits
	localparam int S_OC    = 0;
	localparam int S_UC    = 1;
	localparam int S_IOC   = 2;
	localparam int S_PEAK  = 3;
	localparam int S_AVG   = 4;
	localparam int S_SHORT = 5;
	localparam int STAT_W  = 6;
	// field positions
	localparam int F_TRAIL   = 8;
	localparam int F_SLOPE_H = 16;
	localparam int F_LCOEF   = 8;
	localparam int F_TCOEF   = 16;
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h01;
	localparam logic [15:0]       OC_RST   = 16'h7fff;
endpackage : csp_pkg

/* File: core/csp_core.sv */
// current sense processor: estimator, compensation, blanking, averaging,
// faults, peak limit, pwm gating and wishbone register slave
// assumes pwm and comparator inputs are synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module csp_core #(
	parameter longint CLK_HZ   = csp_pkg::CLK_HZ,
	parameter int     NPWM     = 12,
	parameter int     MEAS_IDX = 0,
	parameter int     TRI_A    = 6,
	parameter int     TRI_B    = 11
) (
	// system
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// wishbone slave
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [7:0]                adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [31:0]               dat_i,
	output logic      [31:0]               dat_o,
	output logic                           ack_o,
	// converter front end
	input  wire logic [4:0]                cmp_i,
	output logic      [9:0]                dac_code_o,
	output logic                           gain_high_o,
	output logic                           ref_pin_sel_o,
	// temperature and loop
	input  wire logic signed [7:0]         temp_delta_i,
	input  wire logic [csp_pkg::EST_W-1:0] err_thr_i,
	// pwm path
	input  wire logic [NPWM-1:0]           pwm_i,
	input  wire logic                      hw_hiz_i,
	output logic      [NPWM-1:0]           pwm_o,
	output logic      [NPWM-1:0]           pwm_oe_n_o,
	// interrupt
	output logic                           irq_o
);
	localparam longint SMP_DIV_L = (CLK_HZ / csp_pkg::SAMPLE_HZ) < 1 ? 1 : CLK_HZ / csp_pkg::SAMPLE_HZ;
	localparam longint PK_DIV_L  = (CLK_HZ / csp_pkg::PEAK_HZ) < 1 ? 1 : CLK_HZ / csp_pkg::PEAK_HZ;
	localparam longint BLK_L     = csp_pkg::BLANK_MAX_NS * CLK_HZ / csp_pkg::NS_PER_S;
	localparam logic [7:0] SMP_DIV   = 8'(SMP_DIV_L);
	localparam logic [7:0] PK_DIV    = 8'(PK_DIV_L);
	localparam logic [3:0] BLANK_MAX = 4'(BLK_L < 1 ? 1 : BLK_L);
	localparam logic [3:0] AVG_N     = 4'(1 << csp_pkg::AVG_LOG2);
	localparam int W = csp_pkg::CUR_W;

	////////////////////////////////////////////////////////////////////////////
	// functions
	function automatic logic signed [4:0] step_of(input logic [4:0] c);
		logic [2:0] n;
		n = 3'(c[0]) + 3'(c[1]) + 3'(c[2]) + 3'(c[3]) + 3'(c[4]);
		step_of = 5'(signed'({2'b00, n, 1'b0})) - 5'sd5;
	endfunction

	function automatic logic [3:0] blank_clamp(input logic [3:0] v);
		blank_clamp = (v > BLANK_MAX) ? BLANK_MAX : v;
	endfunction

	function automatic logic signed [W-1:0] scale_sub(input logic signed [W-1:0] x,
		input logic signed [W-1:0] k, input int sh);
		logic signed [2*W-1:0] p;
		p = x * k;
		scale_sub = x - W'(p >>> sh);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [csp_pkg::CTRL_W-1:0]   ctrl_reg;
	logic [csp_pkg::EST_W-1:0]    offset_reg;
	logic [3:0]                   blank_lead_reg;
	logic [3:0]                   blank_trail_reg;
	logic signed [15:0]           slope_on_reg;
	logic signed [15:0]           slope_off_reg;
	logic [3:0]                   corr_sh_reg;
	logic [7:0]                   lcoef_reg;
	logic [7:0]                   tcoef_reg;
	logic signed [W-1:0]          oc_reg;
	logic signed [W-1:0]          uc_reg;
	logic signed [W-1:0]          ioc_reg;
	logic [csp_pkg::EST_W-1:0]    peak_reg;
	logic [NPWM-1:0]              hiz_fw_reg;
	logic [csp_pkg::STAT_W-1:0]   stat_reg;
	logic [csp_pkg::STAT_W-1:0]   mask_reg;
	logic [csp_pkg::STAT_W-1:0]   ev;
	logic                         wr;
	logic [31:0]                  rd_next;

	assign wr = cyc_i && stb_i && we_i && !ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg        <= csp_pkg::CTRL_RST;
			offset_reg      <= '0;
			blank_lead_reg  <= '0;
			blank_trail_reg <= '0;
			slope_on_reg    <= '0;
			slope_off_reg   <= '0;
			corr_sh_reg     <= '0;
			lcoef_reg       <= '0;
			tcoef_reg       <= '0;
			oc_reg          <= W'(csp_pkg::OC_RST);
			uc_reg          <= '0;
			ioc_reg         <= W'(csp_pkg::OC_RST);
			peak_reg        <= '1;
			hiz_fw_reg      <= '0;
			mask_reg        <= '0;
		end else if (wr && sel_i == 4'hf) begin
			if (adr_i == csp_pkg::A_CTRL) begin
				ctrl_reg <= dat_i[csp_pkg::CTRL_W-1:0];
			end else if (adr_i == csp_pkg::A_OFFSET) begin
				offset_reg <= dat_i[csp_pkg::EST_W-1:0];
			end else if (adr_i == csp_pkg::A_BLANK) begin
				blank_lead_reg  <= blank_clamp(dat_i[3:0]);
				blank_trail_reg <= blank_clamp(dat_i[csp_pkg::F_TRAIL +: 4]);
			end else if (adr_i == csp_pkg::A_SLOPE) begin
				slope_on_reg  <= dat_i[15:0];
				slope_off_reg <= dat_i[csp_pkg::F_SLOPE_H +: 16];
			end else if (adr_i == csp_pkg::A_CORR) begin
				corr_sh_reg <= dat_i[3:0];
				lcoef_reg   <= dat_i[csp_pkg::F_LCOEF +: 8];
				tcoef_reg   <= dat_i[csp_pkg::F_TCOEF +: 8];
			end else if (adr_i == csp_pkg::A_OC) begin
				oc_reg <= dat_i[W-1:0];
			end else if (adr_i == csp_pkg::A_UC) begin
				uc_reg <= dat_i[W-1:0];
			end else if (adr_i == csp_pkg::A_IOC) begin
				ioc_reg <= dat_i[W-1:0];
			end else if (adr_i == csp_pkg::A_PEAK) begin
				peak_reg <= dat_i[csp_pkg::EST_W-1:0];
			end else if (adr_i == csp_pkg::A_HIZ) begin
				hiz_fw_reg <= dat_i[NPWM-1:0];
			end else if (adr_i == csp_pkg::A_MASK) begin
				mask_reg <= dat_i[csp_pkg::STAT_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// rate strobes
	logic [7:0] smp_cnt_reg;
	logic [7:0] pk_cnt_reg;
	logic       smp_en;
	logic       pk_en;

	assign smp_en = (smp_cnt_reg == 8'h00);
	assign pk_en  = (pk_cnt_reg == 8'h00);

	always_ff @(posedge clk_i) begin
		if (rst_i || smp_en) begin
			smp_cnt_reg <= SMP_DIV - 8'h01;
		end else begin
			smp_cnt_reg <= smp_cnt_reg - 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || pk_en) begin
			pk_cnt_reg <= PK_DIV - 8'h01;
		end else begin
			pk_cnt_reg <= pk_cnt_reg - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pwm edges and blanking
	logic       pwm_d_reg;
	logic       rise;
	logic       fall;
	logic [3:0] blank_cnt_reg;
	logic       blanked;

	assign rise    = pwm_i[MEAS_IDX] && !pwm_d_reg;
	assign fall    = !pwm_i[MEAS_IDX] && pwm_d_reg;
	assign blanked = (blank_cnt_reg != 4'h0) || ((rise || fall) && blank_lead_reg != 4'h0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_d_reg <= 1'b0;
		end else begin
			pwm_d_reg <= pwm_i[MEAS_IDX];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blank_cnt_reg <= '0;
		end else if (rise) begin
			blank_cnt_reg <= blank_lead_reg;
		end else if (fall) begin
			blank_cnt_reg <= blank_trail_reg;
		end else if (blank_cnt_reg != 4'h0) begin
			blank_cnt_reg <= blank_cnt_reg - 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// current estimator
	logic [csp_pkg::EST_W-1:0] est_reg;
	logic [csp_pkg::EST_W-1:0] est_prev_reg;
	logic signed [15:0]        est_sum;
	logic signed [15:0]        corr;
	logic signed [15:0]        slope;

	always_comb begin
		slope = pwm_i[MEAS_IDX] ? slope_on_reg : slope_off_reg;
		// quantized tracking error, dropped while blanked
		corr  = blanked ? 16'sd0 : (16'(step_of(cmp_i)) <<< corr_sh_reg);
		est_sum = signed'({3'b000, est_reg}) + slope + corr;
	end

	// tracking estimate; primary or secondary shape
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			est_reg      <= '0;
			est_prev_reg <= '0;
		end else if (smp_en) begin
			est_prev_reg <= est_reg;
			if (ctrl_reg[csp_pkg::C_PRIMARY] && !pwm_i[MEAS_IDX]) begin
				est_reg <= '0;
			end else if (est_sum < 16'sd0) begin
				est_reg <= '0;
			end else if (est_sum > 16'(csp_pkg::EST_MAX)) begin
				est_reg <= csp_pkg::EST_W'(csp_pkg::EST_MAX);
			end else begin
				est_reg <= est_sum[csp_pkg::EST_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// scaling and compensation
	logic signed [W-1:0] raw;
	logic signed [W-1:0] lcorr;
	logic signed [W-1:0] tcorr;
	logic signed [W-1:0] cur_reg;
	logic signed [W-1:0] lsb;

	always_comb begin
		lsb = ctrl_reg[csp_pkg::C_GAIN_HIGH] ? W'(csp_pkg::LSB_HIGH_UV) : W'(csp_pkg::LSB_LOW_UV);
		raw = (W'(est_reg) - W'(offset_reg)) * lsb;
		lcorr = ctrl_reg[csp_pkg::C_LCOMP_EN]
			? raw - ((W'(est_reg) - W'(est_prev_reg)) * W'(lcoef_reg) * lsb >>> csp_pkg::LC_SHIFT)
			: raw;
		tcorr = ctrl_reg[csp_pkg::C_TCOMP_EN]
			? scale_sub(lcorr, W'(temp_delta_i) * W'(tcoef_reg), csp_pkg::TC_SHIFT)
			: lcorr;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_reg <= '0;
		end else if (smp_en) begin
			cur_reg <= tcorr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per cycle average
	logic signed [W+3:0] acc_reg;
	logic [3:0]          acc_n_reg;
	logic signed [W-1:0] avg_reg;

	// fixed sample count per cycle keeps divide a shift
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_reg   <= '0;
			acc_n_reg <= '0;
			avg_reg   <= '0;
		end else if (rise) begin
			if (acc_n_reg == AVG_N) begin
				avg_reg <= W'(acc_reg >>> csp_pkg::AVG_LOG2);
			end
			acc_reg   <= '0;
			acc_n_reg <= '0;
		end else if (smp_en && !blanked && acc_n_reg != AVG_N) begin
			acc_reg   <= acc_reg + (W+4)'(tcorr);
			acc_n_reg <= acc_n_reg + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// peak limit and pulse cut
	logic cut_reg;
	logic peak_trip;
	logic mode_trip;

	assign peak_trip = pk_en && pwm_i[MEAS_IDX] && (est_reg >= peak_reg);
	assign mode_trip = ctrl_reg[csp_pkg::C_PEAK_MODE] && smp_en && pwm_i[MEAS_IDX] && (est_reg >= err_thr_i);

	// cut held to next cycle start
	always_ff @(posedge clk_i) begin
		if (rst_i || rise) begin
			cut_reg <= 1'b0;
		end else if (peak_trip || mode_trip) begin
			cut_reg <= 1'b1;
		end
	end

	// hardware tristate on two outputs only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_o      <= '0;
			pwm_oe_n_o <= '1;
		end else begin
			for (int i = 0; i < NPWM; i++) begin
				pwm_o[i]      <= pwm_i[i] && !(cut_reg && !rise) && !peak_trip;
				pwm_oe_n_o[i] <= hiz_fw_reg[i] || (hw_hiz_i && (i == TRI_A || i == TRI_B));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// faults and interrupt
	always_comb begin
		ev = '0;
		ev[csp_pkg::S_OC]    = rise && acc_n_reg == AVG_N && W'(acc_reg >>> csp_pkg::AVG_LOG2) > oc_reg;
		ev[csp_pkg::S_UC]    = rise && acc_n_reg == AVG_N && W'(acc_reg >>> csp_pkg::AVG_LOG2) < uc_reg;
		ev[csp_pkg::S_IOC]   = ctrl_reg[csp_pkg::C_PEAK_MODE] && pwm_i[MEAS_IDX] && cur_reg > ioc_reg;
		ev[csp_pkg::S_PEAK]  = peak_trip;
		ev[csp_pkg::S_AVG]   = rise && acc_n_reg == AVG_N;
		ev[csp_pkg::S_SHORT] = rise && acc_n_reg != AVG_N;
	end

	// new events win over a same cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_reg <= '0;
		end else if (wr && sel_i[0] && adr_i == csp_pkg::A_STAT) begin
			stat_reg <= (stat_reg & ~dat_i[csp_pkg::STAT_W-1:0]) | ev;
		end else begin
			stat_reg <= stat_reg | ev;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat_reg & mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// front end drive and bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dac_code_o    <= '0;
			gain_high_o   <= 1'b0;
			ref_pin_sel_o <= 1'b0;
		end else begin
			dac_code_o    <= est_reg[csp_pkg::EST_W-1:csp_pkg::EST_FRAC];
			gain_high_o   <= ctrl_reg[csp_pkg::C_GAIN_HIGH];
			// reference pin only in stage mode; board supplies common mode
			ref_pin_sel_o <= ctrl_reg[csp_pkg::C_STAGE_MODE];
		end
	end

	always_comb begin
		rd_next = '0;
		if (adr_i == csp_pkg::A_CTRL) begin
			rd_next[csp_pkg::CTRL_W-1:0] = ctrl_reg;
		end else if (adr_i == csp_pkg::A_OFFSET) begin
			rd_next[csp_pkg::EST_W-1:0] = offset_reg;
		end else if (adr_i == csp_pkg::A_BLANK) begin
			rd_next = {20'h00000, blank_trail_reg, 4'h0, blank_lead_reg};
		end else if (adr_i == csp_pkg::A_SLOPE) begin
			rd_next = {slope_off_reg, slope_on_reg};
		end else if (adr_i == csp_pkg::A_CORR) begin
			rd_next = {8'h00, tcoef_reg, lcoef_reg, 4'h0, corr_sh_reg};
		end else if (adr_i == csp_pkg::A_OC) begin
			rd_next = 32'(oc_reg);
		end else if (adr_i == csp_pkg::A_UC) begin
			rd_next = 32'(uc_reg);
		end else if (adr_i == csp_pkg::A_IOC) begin
			rd_next = 32'(ioc_reg);
		end else if (adr_i == csp_pkg::A_PEAK) begin
			rd_next[csp_pkg::EST_W-1:0] = peak_reg;
		end else if (adr_i == csp_pkg::A_HIZ) begin
			rd_next[NPWM-1:0] = hiz_fw_reg;
		end else if (adr_i == csp_pkg::A_STAT) begin
			rd_next[csp_pkg::STAT_W-1:0] = stat_reg;
		end else if (adr_i == csp_pkg::A_MASK) begin
			rd_next[csp_pkg::STAT_W-1:0] = mask_reg;
		end else if (adr_i == csp_pkg::A_EST) begin
			rd_next[csp_pkg::EST_W-1:0] = est_reg;
		end else if (adr_i == csp_pkg::A_AVG) begin
			rd_next = 32'(avg_reg);
		end else if (adr_i == csp_pkg::A_CUR) begin
			rd_next = 32'(cur_reg);
		end
	end

	// one wait state; unmapped reads zero, writes dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
			dat_o <= rd_next;
		end
	end
endmodule // csp_core
`default_nettype wire

/* File: sim/csp_core_checker.sv */
// port checker for csp_core: bus handshake, front end, pwm gating
// assumes one clock domain; bound to every csp_core below
`timescale 1ns/1ps
`default_nettype none
module csp_core_checker #(
	parameter int NPWM = 12
) (
	// system
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	// bus
	input wire logic                      cyc_i,
	input wire logic                      stb_i,
	input wire logic                      we_i,
	input wire logic [7:0]                adr_i,
	input wire logic [3:0]                sel_i,
	input wire logic [31:0]               dat_i,
	input wire logic [31:0]               dat_o,
	input wire logic                      ack_o,
	// front end
	input wire logic [4:0]                cmp_i,
	input wire logic [9:0]                dac_code_o,
	input wire logic                      gain_high_o,
	input wire logic                      ref_pin_sel_o,
	input wire logic signed [7:0]         temp_delta_i,
	input wire logic [csp_pkg::EST_W-1:0] err_thr_i,
	// pwm and interrupt
	input wire logic [NPWM-1:0]           pwm_i,
	input wire logic                      hw_hiz_i,
	input wire logic [NPWM-1:0]           pwm_o,
	input wire logic [NPWM-1:0]           pwm_oe_n_o,
	input wire logic                      irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic take    = cyc_i && stb_i && !ack_o;
	wire logic ctrl_wr = take && we_i && sel_i == 4'hf && adr_i == csp_pkg::A_CTRL;
	////////////////////////////////
	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
	property p_ack_resp; take |=> ack_o; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack late");
	property p_unmapped; take && !we_i && adr_i == 8'h3c |=> dat_o == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_dac_range; dac_code_o < 10'd640; endproperty
	a_dac_range: assert property (p_dac_range) else $error("dac code out of range");
	property p_gain; ctrl_wr |=> ##1 gain_high_o == $past(dat_i[0], 2); endproperty
	a_gain: assert property (p_gain) else $error("gain select wrong");
	property p_ref; ctrl_wr |=> ##1 ref_pin_sel_o == $past(dat_i[1], 2); endproperty
	a_ref: assert property (p_ref) else $error("reference select wrong");
	property p_hiz; hw_hiz_i |=> pwm_oe_n_o[6] && pwm_oe_n_o[11]; endproperty
	a_hiz: assert property (p_hiz) else $error("tristate pins driven");
	property p_gate; (pwm_o & ~$past(pwm_i)) == '0; endproperty
	a_gate: assert property (p_gate) else $error("pwm output without input");
	c_write: cover property (ctrl_wr);
	c_cut: cover property (pwm_i[0] && $past(pwm_i[0]) && pwm_o == '0);
	c_hiz: cover property (hw_hiz_i ##1 pwm_oe_n_o[11]);
	c_irq: cover property ($rose(irq_o));
endmodule // csp_core_checker
bind csp_core csp_core_checker #(.NPWM(NPWM)) i_csp_core_checker (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_i(cmp_i), .dac_code_o(dac_code_o),
	.gain_high_o(gain_high_o), .ref_pin_sel_o(ref_pin_sel_o), .temp_delta_i(temp_delta_i),
	.err_thr_i(err_thr_i), .pwm_i(pwm_i), .hw_hiz_i(hw_hiz_i), .pwm_o(pwm_o),
	.pwm_oe_n_o(pwm_oe_n_o), .irq_o(irq_o));
`default_nettype wire

/* File: sim/csp_sense_model.sv */
// sense front end model: five comparators on the tracking error
// assumes dac code and gain from csp_core; bench sets input in microvolts
`timescale 1ns/1ps
`default_nettype none
module csp_sense_model (
	// core side
	input  wire logic        clk_i,
	input  wire logic [9:0]  dac_code_i,
	input  wire logic        gain_high_i,
	input  wire logic        ref_pin_sel_i,
	output logic      [4:0]  cmp_o,
	// bench side
	input  wire logic [31:0] sense_uv_i,
	input  wire logic        slow_i
);
	int         ref_uv;
	int         pin_uv;
	int         err;
	logic [4:0] now_c;
	logic [4:0] old_r;
	always_comb begin
		// common mode 1.2 V only in stage mode
		ref_uv = ref_pin_sel_i ? 1200000 : 0;
		pin_uv = ref_uv + int'(sense_uv_i);
		err = (pin_uv - ref_uv) / (gain_high_i ? 100 : 1450) - int'(dac_code_i);
		now_c = err > 4 ? 5'h1f : err > 2 ? 5'h0f : err > 0 ? 5'h07 : err > -2 ? 5'h03 : err > -4 ? 5'h01 : 5'h00;
	end
	// slow comparators answer a cycle late
	always_ff @(posedge clk_i) old_r <= now_c;
	assign cmp_o = slow_i ? old_r : now_c;
endmodule // csp_sense_model
`default_nettype wire

/* File: sim/csp_core_tb_top.sv */
// self-checking bench for csp_core with the sense front end model
// assumes csp_pkg, csp_core, checker and model compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module csp_core_tb_top;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              cyc = 1'b0;
	logic              stb = 1'b0;
	logic              we = 1'b0;
	logic [7:0]        adr = 8'h00;
	logic [3:0]        sel = 4'h0;
	logic [31:0]       wdat = 32'h0;
	logic signed [7:0] temp = 8'sh00;
	logic [12:0]       thr = 13'h1fff;
	logic [11:0]       pwm = 12'h000;
	logic              hwz = 1'b0;
	logic              slow = 1'b0;
	logic [31:0]       uv = 32'd30000;
	logic [31:0]       rdat, q, c;
	logic              ack, gain, refsel, irq;
	logic [4:0]        cmp;
	logic [9:0]        dac;
	logic [11:0]       pwmo, oen;
	int                n_mismatch = 0;
	int                samples_checked = 0;
	always #50 clk = ~clk;
	csp_core #(.NPWM(12)) i_csp_core (
		.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .cmp_i(cmp), .dac_code_o(dac), .gain_high_o(gain),
		.ref_pin_sel_o(refsel), .temp_delta_i(temp), .err_thr_i(thr), .pwm_i(pwm), .hw_hiz_i(hwz),
		.pwm_o(pwmo), .pwm_oe_n_o(oen), .irq_o(irq));
	csp_sense_model i_csp_sense_model (.clk_i(clk), .dac_code_i(dac), .gain_high_i(gain),
		.ref_pin_sel_i(refsel), .cmp_o(cmp), .sense_uv_i(uv), .slow_i(slow));
	////////////////////////////////
	task automatic complete_run();
		$display("compares %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// classic single cycle; bounded wait on ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 40) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0);
	endtask
	function automatic logic near(input logic [9:0] v, input int t);
		return v >= t - 4 && v <= t + 4;
	endfunction
	task automatic run(input int per, input int n);
		repeat (n) for (int i = 0; i < per; i++) begin
			@(posedge clk);
			pwm <= (i < per / 2) ? 12'hfff : 12'h000;
		end
	endtask
	task automatic pulse(input logic [11:0] e);
		repeat (4) @(posedge clk);
		pwm <= 12'hfff;
		repeat (4) @(posedge clk);
		`CHK(pwmo, e)
		pwm <= 12'h000;
	endtask
	////////////////////////////////
	task automatic t_regs();
		rd(csp_pkg::A_CTRL);
		`CHK(q, 32'h1)
		rd(csp_pkg::A_IOC);
		`CHK(q, 32'h7fff)
		rd(csp_pkg::A_PEAK);
		`CHK(q[12:0], 13'h1fff)
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c);
		`CHK(q, 32'h0)
		`CHK(gain, 1'b1)
	endtask
	task automatic t_gain_ref();
		for (int i = 3; i >= 0; i--) begin
			wr(csp_pkg::A_CTRL, 32'(i));
			repeat (2) @(posedge clk);
			`CHK({refsel, gain}, 2'(i))
		end
	endtask
	task automatic t_track();
		wr(csp_pkg::A_BLANK, 32'h0);
		wr(csp_pkg::A_SLOPE, 32'h0);
		wr(csp_pkg::A_CORR, 32'h0);
		wr(csp_pkg::A_CTRL, 32'h1);
		repeat (700) @(posedge clk);
		`CHK(near(dac, 300), 1'b1)
		rd(csp_pkg::A_EST);
		`CHK(near(q[12:3], 300) && q[31:13] == 0, 1'b1)
		slow <= 1'b1;
		uv <= 32'd20000;
		repeat (300) @(posedge clk);
		`CHK(near(dac, 200), 1'b1)
		wr(csp_pkg::A_CTRL, 32'h0);
		uv <= 32'd290000;
		repeat (50) @(posedge clk);
		`CHK(near(dac, 200), 1'b1)
		wr(csp_pkg::A_CTRL, 32'h5);
		repeat (4) @(posedge clk);
		`CHK(dac, 10'h0)
		wr(csp_pkg::A_CTRL, 32'h1);
		uv <= 32'd30000;
		slow <= 1'b0;
		repeat (600) @(posedge clk);
	endtask
	// clamp makes 0x0f0f act as 2 and 2 cycles
	task automatic t_blank();
		logic [31:0] cfg [3] = '{32'h0, 32'h0202, 32'h0f0f};
		int          per [3] = '{10, 10, 16};
		for (int i = 0; i < 3; i++) begin
			wr(csp_pkg::A_BLANK, cfg[i]);
			wr(csp_pkg::A_STAT, 32'h3f);
			run(per[i], 4);
			rd(csp_pkg::A_STAT);
			`CHK(q[5:4], {i == 1, 1'b1})
		end
		rd(csp_pkg::A_AVG);
		`CHK(near(10'(q / 800), 300), 1'b1)
		wr(csp_pkg::A_MASK, 32'h10);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		wr(csp_pkg::A_MASK, 32'h20);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		wr(csp_pkg::A_MASK, 32'h10);
		wr(csp_pkg::A_STAT, 32'h10);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
	endtask
	task automatic t_peak();
		wr(csp_pkg::A_CTRL, 32'h9);
		wr(csp_pkg::A_IOC, 32'h0);
		wr(csp_pkg::A_STAT, 32'h3f);
		thr <= 13'd800;
		pulse(12'h000);
		rd(csp_pkg::A_STAT);
		`CHK(q[3:2], 2'b01)
		thr <= 13'h1fff;
		pulse(12'hfff);
		wr(csp_pkg::A_PEAK, 32'd800);
		pulse(12'h000);
		rd(csp_pkg::A_STAT);
		`CHK(q[3], 1'b1)
		wr(csp_pkg::A_PEAK, 32'h1fff);
	endtask
	task automatic t_fault();
		wr(csp_pkg::A_CTRL, 32'h1);
		wr(csp_pkg::A_OC, 32'h0);
		wr(csp_pkg::A_UC, 32'h1ff_ffff);
		wr(csp_pkg::A_STAT, 32'h3f);
		run(16, 3);
		rd(csp_pkg::A_STAT);
		`CHK(q[1:0], 2'b11)
		rd(csp_pkg::A_CUR);
		c = q;
		temp <= 8'sh40;
		wr(csp_pkg::A_CORR, 32'h40_0000);
		wr(csp_pkg::A_CTRL, 32'h21);
		repeat (8) @(posedge clk);
		rd(csp_pkg::A_CUR);
		`CHK(q !== c, 1'b1)
	endtask
	task automatic t_hiz();
		hwz <= 1'b1;
		wr(csp_pkg::A_HIZ, 32'h0);
		repeat (2) @(posedge clk);
		`CHK(oen, 12'h840)
		hwz <= 1'b0;
		wr(csp_pkg::A_HIZ, 32'h5);
		repeat (2) @(posedge clk);
		`CHK(oen, 12'h005)
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_gain_ref();
		t_track();
		t_blank();
		t_peak();
		t_fault();
		t_hiz();
		complete_run();
	end
endmodule // csp_core_tb_top
`default_nettype wire
